// >>> logic/watchdog_pkg.sv
// Purpose: types for the windowed watchdog timer
// Assumes: constants come from watchdog_regs.svh
// Notes: none
`include "watchdog_regs.svh"
package watchdog_pkg;
  typedef struct packed {
    logic hw_enable;
    logic window_disable;
    logic reserved;
    logic prescale_select;
    logic [3:0] postscale_select;
  } watchdog_config_word_t;

  typedef struct packed {
    logic clock_switch_done;
    logic power_save_instr;
    logic wake_exit;
    logic watchdog_clear_instr;
  } clear_events_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_SAVE = 3'h2,
    ST_WAKE = 3'h4
  } power_state_t;
endpackage

// >>> logic/watchdog_regs.svh
// Purpose: constants for the windowed watchdog timer
// Assumes: 100 MHz system clock, 32 kHz low-power oscillator tick input
// Notes: bit positions refer to the configuration word and reset-control reg
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

`define CFG_POSTSCALE_LSB 0
`define CFG_POSTSCALE_W 4
`define CFG_PRESCALE_BIT 4
`define CFG_WINDOW_DISABLE_BIT 6
`define CFG_HW_ENABLE_BIT 7
`define CFG_WORD_W 8
`define STATUS_IDLE_BIT 2
`define STATUS_SLEEP_BIT 3
`define STATUS_TIMEOUT_BIT 4
`define STATUS_SW_ENABLE_BIT 5
`define PRESCALE_SHORT 32
`define PRESCALE_LONG 128
`define PRESCALE_CNT_W 7
`define POSTSCALE_CNT_W 15
`define OSC_NOMINAL_HZ 32000
`define PERIOD_SHORT_MS 1
`define PERIOD_LONG_MS 4

`endif

// >>> logic/windowed_watchdog_timer.sv
// Purpose: windowed watchdog timer on a low-power oscillator tick
// Assumes: osc tick is a level toggling at the oscillator rate, async
// Notes: config word and events arrive from same-clock core logic
`include "watchdog_regs.svh"

module windowed_watchdog_timer
  import watchdog_pkg::*;
#(
  parameter int PRE_W = `PRESCALE_CNT_W,
  parameter int POST_W = `POSTSCALE_CNT_W,
  parameter int PRE_SHORT_DIV = `PRESCALE_SHORT,
  parameter int PRE_LONG_DIV = `PRESCALE_LONG
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic osc_tick_in,
  input wire watchdog_config_word_t config_in,
  input wire clear_events_t events_in,
  input wire logic sw_enable_set_in,
  input wire logic sw_enable_clr_in,
  input wire logic timeout_flag_clr_in,
  input wire logic sleep_enter_in,
  input wire logic status_clr_in,
  output logic low_power_rc_osc_en_out,
  output logic watchdog_reset_out,
  output logic wake_out,
  output logic sw_watchdog_enable_out,
  output logic timeout_flag_out,
  output logic sleep_flag_out,
  output logic idle_flag_out,
  output logic in_save_out
);
  localparam int PERIOD_SHORT_CYC = `OSC_NOMINAL_HZ / 1000 * `PERIOD_SHORT_MS;
  localparam int PERIOD_LONG_CYC = `OSC_NOMINAL_HZ / 1000 * `PERIOD_LONG_MS;

  // elaboration checks on what the counters rely on
  if (PERIOD_SHORT_CYC != `PRESCALE_SHORT ||
      PERIOD_LONG_CYC != `PRESCALE_LONG) begin : g_bad_nominal
    $error("prescale ratios do not match nominal periods");
  end
  if (PRE_SHORT_DIV < 2 || PRE_LONG_DIV <= PRE_SHORT_DIV) begin : g_bad_div
    $error("prescale ratios out of range");
  end
  if (((PRE_LONG_DIV - 1) >> PRE_W) != 0) begin : g_bad_pre_w
    $error("prescale counter too narrow for the long ratio");
  end
  if (POST_W < (1 << `CFG_POSTSCALE_W) - 1) begin : g_bad_post_w
    $error("postscale counter too narrow for the code range");
  end
  if ($bits(watchdog_config_word_t) != `CFG_WORD_W) begin : g_bad_cfg_w
    $error("config word width mismatch");
  end

  logic [2:0] tick_sync_r;
  logic tick_prev_r;
  logic tick_edge;
  logic enabled;
  logic clear_all;
  logic [PRE_W-1:0] pre_cnt_r;
  logic [PRE_W-1:0] pre_last;
  logic pre_wrap;
  logic [POST_W-1:0] post_cnt_r;
  logic [POST_W-1:0] post_last;
  logic [POST_W-1:0] post_quarter;
  logic in_window;
  logic timeout;
  logic early_clear;
  power_state_t pstate_r;

  // oscillator tick crosses with three flops, edge when 2nd and 3rd agree
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_sync_r <= 3'h0;
      tick_prev_r <= 1'b0;
    end else begin
      tick_sync_r <= {tick_sync_r[1:0], osc_tick_in};
      if (tick_sync_r[2] == tick_sync_r[1]) begin
        tick_prev_r <= tick_sync_r[2];
      end
    end
  end
  assign tick_edge = (tick_sync_r[2] == tick_sync_r[1]) &&
                     tick_sync_r[2] && !tick_prev_r;

  // hardware bit forces the watchdog on, else the software bit
  assign enabled = config_in.hw_enable || sw_watchdog_enable_out;

  // terminal counts for the selected ratios
  always_comb begin
    pre_last = config_in.prescale_select ?
      PRE_W'(PRE_LONG_DIV - 1) :
      PRE_W'(PRE_SHORT_DIV - 1);
    post_last = POST_W'((32'h1 << config_in.postscale_select)
                        - 32'h1);
    post_quarter = post_last - (post_last >> 2);
  end

  assign pre_wrap = tick_edge && (pre_cnt_r == pre_last);
  // a clear landing on the final tick wins over the time-out
  assign timeout = enabled && pre_wrap && (post_cnt_r == post_last) &&
                   !clear_all;
  // window opens once the count reaches the last quarter
  assign in_window = (post_cnt_r >= post_quarter);
  assign early_clear = enabled && events_in.watchdog_clear_instr &&
                       (pstate_r == ST_RUN) &&
                       !config_in.window_disable &&
                       !in_window;
  assign clear_all = events_in.clock_switch_done ||
                     events_in.power_save_instr || events_in.wake_exit ||
                     events_in.watchdog_clear_instr || !enabled;

  // prescaler and postscaler counters
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_all || timeout) begin
      pre_cnt_r <= '0;
      post_cnt_r <= '0;
    end else if (tick_edge) begin
      if (pre_wrap) begin
        pre_cnt_r <= '0;
        post_cnt_r <= post_cnt_r + POST_W'(1);
      end else begin
        pre_cnt_r <= pre_cnt_r + PRE_W'(1);
      end
    end
  end

  // power-save state, counting continues in sleep and idle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pstate_r <= ST_RUN;
    end else begin
      case (pstate_r)
        ST_RUN: begin
          if (events_in.power_save_instr) begin
            pstate_r <= ST_SAVE;
          end
        end
        ST_SAVE: begin
          if (timeout) begin
            pstate_r <= ST_WAKE;
          end else if (events_in.wake_exit) begin
            pstate_r <= ST_RUN;
          end
        end
        ST_WAKE: pstate_r <= ST_RUN;
        default: pstate_r <= ST_RUN;
      endcase
    end
  end

  // outputs toward core and reset logic
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      watchdog_reset_out <= 1'b0;
      wake_out <= 1'b0;
      in_save_out <= 1'b0;
      low_power_rc_osc_en_out <= 1'b0;
    end else begin
      watchdog_reset_out <= (timeout && pstate_r == ST_RUN) ||
                            early_clear;
      wake_out <= timeout && pstate_r == ST_SAVE;
      in_save_out <= (pstate_r == ST_SAVE);
      low_power_rc_osc_en_out <= enabled;
    end
  end

  // software enable bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sw_watchdog_enable_out <= 1'b0;
    end else if (sw_enable_set_in) begin
      sw_watchdog_enable_out <= 1'b1;
    end else if (sw_enable_clr_in) begin
      sw_watchdog_enable_out <= 1'b0;
    end
  end

  // sticky time-out flag, set wins over clear; survives device reset
  always_ff @(posedge clk_in) begin
    if (timeout) begin
      timeout_flag_out <= 1'b1;
    end else if (timeout_flag_clr_in) begin
      timeout_flag_out <= 1'b0;
    end else if (rst_in && !timeout_flag_out) begin
      timeout_flag_out <= 1'b0;
    end
  end

  // sleep and idle status, left set after wake for software to clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sleep_flag_out <= 1'b0;
      idle_flag_out <= 1'b0;
    end else if (events_in.power_save_instr) begin
      sleep_flag_out <= sleep_enter_in;
      idle_flag_out <= !sleep_enter_in;
    end else if (status_clr_in) begin
      sleep_flag_out <= 1'b0;
      idle_flag_out <= 1'b0;
    end
  end
endmodule // windowed_watchdog_timer

// >>> testbench/windowed_watchdog_timer_properties.sv
// Purpose: port assertions for the watchdog timer
// Assumes: one clock, sync active-high reset
// Notes: bound into every timer instance
module watchdog_checker
  import watchdog_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic osc_tick_in,
  input wire watchdog_config_word_t config_in,
  input wire clear_events_t events_in,
  input wire logic sw_enable_set_in,
  input wire logic sw_enable_clr_in,
  input wire logic timeout_flag_clr_in,
  input wire logic sleep_enter_in,
  input wire logic status_clr_in,
  input wire logic low_power_rc_osc_en_out,
  input wire logic watchdog_reset_out,
  input wire logic wake_out,
  input wire logic sw_watchdog_enable_out,
  input wire logic timeout_flag_out,
  input wire logic sleep_flag_out,
  input wire logic idle_flag_out,
  input wire logic in_save_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_osc_hw_on: assert property (
    config_in.hw_enable |=> low_power_rc_osc_en_out) else $error("osc off");
  chk_osc_off: assert property (!config_in.hw_enable &&
    !sw_watchdog_enable_out && !sw_enable_set_in |=> !low_power_rc_osc_en_out)
    else $error("osc on while disabled");
  chk_sw_en_reset: assert property (disable iff (1'b0)
    rst_in |=> !sw_watchdog_enable_out) else $error("sw enable kept");
  chk_flag_sticky: assert property (
    timeout_flag_out && !timeout_flag_clr_in |=> timeout_flag_out)
    else $error("flag dropped");
  chk_flag_clear: assert property (timeout_flag_clr_in |=>
    !timeout_flag_out || wake_out || watchdog_reset_out) else $error("flag");
  chk_wake_flag: assert property (
    wake_out |-> timeout_flag_out) else $error("wake without flag");
  chk_wake_save: assert property (
    wake_out |-> $past(in_save_out)) else $error("wake outside save");
  chk_save_no_rst: assert property (
    in_save_out && $past(in_save_out) |-> !watchdog_reset_out)
    else $error("reset in save");
  chk_window_off: assert property (config_in.window_disable &&
    events_in.watchdog_clear_instr |=> !watchdog_reset_out)
    else $error("early reset in non-window mode");
  cover property (wake_out);
  cover property (watchdog_reset_out);
  cover property (timeout_flag_clr_in ##1 !timeout_flag_out);
endmodule // watchdog_checker

bind windowed_watchdog_timer watchdog_checker i_watchdog_checker (.*);

// >>> testbench/windowed_watchdog_timer_tb.sv
// Purpose: self-checking bench for the watchdog timer
// Assumes: osc tick driven fast, eight clocks a tick
// Notes: driver queues expected pulses, monitor compares
module windowed_watchdog_timer_tb
  import watchdog_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, rst_in = 1'b1, osc_tick_in = 1'b0;
  logic sw_enable_set_in = 1'b0, sw_enable_clr_in = 1'b0;
  logic timeout_flag_clr_in = 1'b0, sleep_enter_in = 1'b0;
  logic status_clr_in = 1'b0;
  watchdog_config_word_t config_in = 8'hC0;
  clear_events_t events_in = 4'h0;
  logic low_power_rc_osc_en_out, watchdog_reset_out, wake_out;
  logic sw_watchdog_enable_out, timeout_flag_out, sleep_flag_out;
  logic idle_flag_out, in_save_out;
  logic [1:0] p, n;
  int n_fail = 0, checks = 0, ticks = 0, cyc = 0, per;
  int exp_q[$];
  windowed_watchdog_timer i_windowed_watchdog_timer (.*);
  initial forever #5 clk_in = ~clk_in;
  task automatic step(int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic pls(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic ev(clear_events_t e);
    events_in = e;
    step(1);
    events_in = 4'h0;
    ticks = 0;
  endtask
  task automatic tick(int k);
    repeat (k) begin
      osc_tick_in = 1'b1;
      step(4);
      ticks++;
      osc_tick_in = 1'b0;
      step(4);
    end
  endtask
  task automatic check(string s, int e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      n_fail++;
      results();
    end
    if (wake_out === 1'b1 || watchdog_reset_out === 1'b1)
      check("pulse", exp_q.pop_front(),
        {10'h0, wake_out, watchdog_reset_out, 20'h0} | ticks);
  end
  initial begin
    void'($urandom(23378));
    step(10);
    rst_in = 1'b0;
    for (int i = 0; i < 4; i++) begin
      p = 2'(i % 2);
      n = (i < 3) ? 2'(i) : 2'($urandom % 3);
      config_in = {3'b110, p[0], 2'h0, n};
      ev(4'h1);
      per = (p[0] ? 128 : 32) << n;
      exp_q.push_back(32'h100000 | per);
      tick(per);
      check("flag", 1, timeout_flag_out);
      pls(timeout_flag_clr_in);
      check("flag", 0, timeout_flag_out);
    end
    $display("test divide done");
    config_in = 8'h41;
    pls(sw_enable_set_in);
    step(1);
    check("swen", 1, sw_watchdog_enable_out);
    check("osc", 1, low_power_rc_osc_en_out);
    ev(4'h8);
    sleep_enter_in = 1'b1;
    ev(4'h4);
    step(1);
    check("save", 1, in_save_out);
    exp_q.push_back(32'h200040);
    tick(64);
    check("sleep", 1, sleep_flag_out);
    check("idle", 0, idle_flag_out);
    ev(4'h2);
    pls(status_clr_in);
    check("sleep", 0, sleep_flag_out);
    sleep_enter_in = 1'b0;
    ev(4'h4);
    check("idle", 1, idle_flag_out);
    ev(4'h2);
    pls(status_clr_in);
    check("idle", 0, idle_flag_out);
    pls(sw_enable_clr_in);
    step(1);
    check("osc", 0, low_power_rc_osc_en_out);
    $display("test save done");
    config_in = 8'h82;
    exp_q.push_back(32'h100000);
    ev(4'h1);
    tick(96);
    ev(4'h1);
    tick(8);
    pls(sw_enable_set_in);
    pls(rst_in);
    check("swen", 0, sw_watchdog_enable_out);
    check("queue", 0, exp_q.size());
    $display("test window done");
    results();
  end
endmodule // windowed_watchdog_timer_tb
